// *** rtl/wsb_bus_ctrl.sv ***
// processor-side multiplexed bus sequencer with grant handover and float mode
`timescale 1ns/1ns
// Overview of operation
// R01: controller delays write enable after slow reads
// R02: partial writes enable only written byte lanes
// R03: change transceiver direction only while disabled
// R04: direction scheme assumes wait-states, system clock
// R05: transceiver enable window from strobes combined
// R06: read enable in time, off with strobe
// R07: write enable held through memory hold; data enable here negates with the write strobe
// R08: write data held half clock after strobe
// R09: direction set before enable, held after
// R10: idle floats bus, controls negated
// R11: bus request answered by float and grant
// R12: granted: float all but clock, grant
// R13: granted: keep running, stall on misses
// R14: handover leaves controls undriven at rest levels
// R15: float mode at reset floats grant too
// R16: controller detects, classifies, counts, acknowledges cycles
// R17: controller master counter zero until cycle
// R18: both clock edges give half-clock turnaround
// R19: double-rate input, system clock output
// R20: outside machines may use either edge
// R21: controls assert rising, deassert falling; data enable here asserts on falling
// R22: word-ready once per burst word, rising
// R23: acknowledge sampled rising, cycle ends falling
// R24: controller reset clears counter, enables
module wsb_bus_ctrl
  import wsb_pkg::*;
(
  input  wire logic                  sys_clk,            // double-rate input clock
  input  wire logic                  rst_b,              // synchronous reset, low active
  // core side
  input  wire logic                  req_valid,          // request offered
  output logic                       req_ready,          // fifo has room
  input  wire wsb_req_t              req_data,           // request contents
  output logic                       rd_valid_q,         // read word returned
  output logic [AD_W-1:0]            rd_data_q,          // returned read word
  output logic                       wr_done_q,          // write cycle finished
  output logic                       core_stall_q,       // core waits for the bus
  // bus pins
  output logic                       sys_clock_out_q,    // half-rate system clock
  output logic [AD_W-1:0]            ad_out_q,           // address/data drive value
  output logic                       ad_oe_q,            // address/data drive enable
  input  wire logic [AD_W-1:0]       ad_in,              // address/data pin level
  output logic                       addr_latch_strobe_q,// address latch strobe
  output logic                       read_strobe_n_q,    // read strobe, low active
  output logic                       write_strobe_n_q,   // write strobe, low active
  output logic                       burst_or_near_write_n_q, // burst/near, low active
  output logic                       data_enable_n_q,    // data enable, low active
  output logic                       ctl_oe_q,           // control pin drive enable
  output logic                       bus_grant_out_q,    // bus granted to outside master
  output logic                       bus_grant_oe_q,     // grant pin drive enable
  input  wire logic                  bus_request_in,     // outside master wants the bus
  input  wire logic                  read_word_ready_n,  // memory word ready, low active
  input  wire logic                  cycle_acknowledge_n,// cycle acknowledge, low active
  input  wire logic [SYNC_IRQ_W-1:0] sync_irq_in         // irq pins, mode vector at reset
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int SYN_W = AD_W + SYNC_IRQ_W + 3;  // width of synchronised pin group

  logic [SYN_W-1:0]      syn1_q;    // first stage, read only by second stage
  logic [SYN_W-1:0]      syn2_q;    // second stage
  logic [AD_W-1:0]       ad_in_s;   // bus level, synchronised
  logic [SYNC_IRQ_W-1:0] irq_s;     // irq pins, synchronised
  logic                  req_s;     // bus request, synchronised
  logic                  rdy_s;     // word ready, high active
  logic                  ack_s;     // acknowledge, high active

  // two flops, no reset so mode pins settle during reset
  always_ff @(posedge sys_clk) begin
    syn1_q <= {ad_in, sync_irq_in, bus_request_in, read_word_ready_n, cycle_acknowledge_n};
    syn2_q <= syn1_q;
  end

  assign ad_in_s = syn2_q[SYN_W-1 -: AD_W];
  assign irq_s   = syn2_q[SYNC_IRQ_W+2 -: SYNC_IRQ_W];
  assign req_s   = syn2_q[2];
  assign rdy_s   = !syn2_q[1];
  assign ack_s   = !syn2_q[0];

  // ************************************************************
  // clock divider and edge phase
  // ************************************************************
  logic phase_q;  // high between rising and falling system clock edges

  // divide by two; phase low means the coming edge is a rising one
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      phase_q <= PHASE_RST;
    end else begin
      phase_q <= !phase_q;  // [R19] [R18]
    end
  end

  assign sys_clock_out_q = phase_q;

  // ************************************************************
  // reset mode vector
  // ************************************************************
  logic float_q;  // float-all mode latched during reset

  // low on the float pin while in reset selects float-all
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      float_q <= !irq_s[FLOAT_BIT];  // [R15]
    end
  end

  // grant pin floats during reset and in float-all mode
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bus_grant_oe_q <= OE_OFF;
    end else begin
      bus_grant_oe_q <= !float_q;  // [R15]
    end
  end

  // ************************************************************
  // request queue
  // ************************************************************
  wsb_req_t fifo_data;   // request at the head
  logic     fifo_valid;  // head holds a request
  logic     fifo_pop;    // head taken into an address phase

  wsb_fifo #(
    .W     ($bits(wsb_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  wsb_state_t state_q;    // sequencer state
  logic [2:0] words_q;    // read words taken this cycle
  logic       end_pend_q; // end the cycle at the next falling edge
  logic       cur_wr_q;   // current cycle is a write
  logic       cur_burst_q;// current cycle is burst or near
  logic [AD_W-1:0] fifo_data_wdata_q;  // write data of the current cycle

  // start a cycle on a rising edge when idle, driven and not requested away
  assign fifo_pop = (state_q == ST_IDLE) && !float_q && !phase_q && !req_s &&
                    fifo_valid && ctl_oe_q;

  // core stalls only when it needs the bus and the bus is away
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      core_stall_q <= 1'b0;
    end else begin
      core_stall_q <= (bus_grant_out_q || float_q) && fifo_valid;  // [R13]
    end
  end

  // ************************************************************
  // bus sequencer
  // ************************************************************
  // state, pins and returned data
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q                 <= ST_IDLE;
      addr_latch_strobe_q     <= ALE_IDLE;
      read_strobe_n_q         <= STROBE_IDLE;
      write_strobe_n_q        <= STROBE_IDLE;
      burst_or_near_write_n_q <= STROBE_IDLE;
      data_enable_n_q         <= STROBE_IDLE;
      ad_oe_q                 <= OE_OFF;
      ad_out_q                <= '0;
      ctl_oe_q                <= OE_OFF;
      bus_grant_out_q         <= 1'b0;
      words_q                 <= WORDS_RST;
      end_pend_q              <= 1'b0;
      cur_wr_q                <= 1'b0;
      cur_burst_q             <= 1'b0;
      rd_valid_q              <= 1'b0;
      rd_data_q               <= '0;
      wr_done_q               <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      wr_done_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // bus floated, all controls already at rest  [R10]
          if (float_q) begin
            state_q  <= ST_FLOAT;
            ctl_oe_q <= OE_OFF;  // [R15]
          end else if (!phase_q) begin
            if (req_s) begin
              // release everything as the grant goes out  [R11] [R12] [R14]
              state_q         <= ST_GRANT;
              bus_grant_out_q <= 1'b1;
              ctl_oe_q        <= OE_OFF;
              ad_oe_q         <= OE_OFF;
            end else if (fifo_pop) begin
              // address phase with byte enables on the low lines  [R21]
              state_q                 <= ST_ADDR;
              addr_latch_strobe_q     <= 1'b1;
              ad_oe_q                 <= 1'b1;
              ad_out_q                <= {fifo_data.addr[AD_W-1:BE_W], fifo_data.byte_en};
              burst_or_near_write_n_q <= !fifo_data.burst;
              cur_wr_q                <= fifo_data.wr;
              cur_burst_q             <= fifo_data.burst;
              words_q                 <= WORDS_RST;
              end_pend_q              <= 1'b0;
            end else begin
              ctl_oe_q <= 1'b1;  // take the controls back a clock after handover
            end
          end
        end
        ST_ADDR: begin
          if (phase_q) begin
            addr_latch_strobe_q <= ALE_IDLE;  // latch strobe drops on falling  [R21]
          end else begin
            state_q <= ST_STROBE;
            if (cur_wr_q) begin
              write_strobe_n_q <= 1'b0;  // asserts on rising  [R21]
              ad_out_q         <= fifo_data_wdata_q;
            end else begin
              read_strobe_n_q <= 1'b0;  // asserts on rising  [R21]
              ad_oe_q         <= OE_OFF;  // let memory drive
            end
          end
        end
        ST_STROBE: begin
          if (phase_q) begin
            if (end_pend_q) begin
              // every control negates on the falling edge  [R21] [R18]
              read_strobe_n_q         <= STROBE_IDLE;
              write_strobe_n_q        <= STROBE_IDLE;
              burst_or_near_write_n_q <= STROBE_IDLE;
              data_enable_n_q         <= STROBE_IDLE;
              end_pend_q              <= 1'b0;
              wr_done_q               <= cur_wr_q;
              state_q                 <= cur_wr_q ? ST_WHOLD : ST_IDLE;
            end else begin
              data_enable_n_q <= 1'b0;  // the one control asserted on falling  [R21]
            end
          end else begin
            if (!cur_wr_q && rdy_s) begin
              // word ready sampled on rising, one word each  [R22]
              rd_valid_q <= 1'b1;
              rd_data_q  <= ad_in_s;
              words_q    <= words_q + 3'h1;
              if (!cur_burst_q || (words_q == BURST_WORDS - 3'h1)) begin
                end_pend_q <= 1'b1;
              end
            end
            if (cur_wr_q && ack_s) begin
              end_pend_q <= 1'b1;  // acknowledge on rising, end on falling  [R23]
            end
          end
        end
        ST_WHOLD: begin
          if (!phase_q) begin
            ad_oe_q <= OE_OFF;  // data held half a clock past the strobe  [R08]
            state_q <= ST_IDLE;
          end
        end
        ST_GRANT: begin
          if (!phase_q && !req_s) begin
            bus_grant_out_q <= 1'b0;  // [R11]
            state_q         <= ST_IDLE;
          end
        end
        ST_FLOAT: begin
          ctl_oe_q <= OE_OFF;  // held until the next reset  [R15]
          ad_oe_q  <= OE_OFF;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // write data kept aside from the popped head

  // captured with the address phase
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fifo_data_wdata_q <= '0;
    end else if (fifo_pop) begin
      fifo_data_wdata_q <= fifo_data.wdata;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_IDLE_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
    (state_q == ST_IDLE) |-> !ad_oe_q && read_strobe_n_q && write_strobe_n_q &&
                             data_enable_n_q && !addr_latch_strobe_q)
    else $error("idle bus not floated or controls not negated");

  AST_GRANT_REPLY: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    (state_q == ST_IDLE && !phase_q && req_s && !float_q) |=> bus_grant_out_q)
    else $error("bus request not granted at the next edge");

  AST_GRANT_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R12]
    bus_grant_out_q |-> !ad_oe_q && !ctl_oe_q && bus_grant_oe_q)
    else $error("outputs driven while bus granted");

  AST_HANDOVER_REST: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    $fell(ctl_oe_q) |-> read_strobe_n_q && write_strobe_n_q &&
                        burst_or_near_write_n_q && data_enable_n_q && !addr_latch_strobe_q)
    else $error("controls released away from rest levels");

  AST_FLOAT_ALL: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R15]
    float_q |=> !bus_grant_oe_q && !ctl_oe_q && !ad_oe_q)
    else $error("float-all mode left an output driven");

  AST_WR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R08]
    $rose(write_strobe_n_q) |-> ad_oe_q ##1 !ad_oe_q)
    else $error("write data not held exactly half a clock");

  AST_CLK_DIV: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R19]
    sys_clock_out_q |=> !sys_clock_out_q ##1 sys_clock_out_q)
    else $error("system clock not half the input rate");

  AST_ASSERT_RISE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R21]
    ($fell(read_strobe_n_q) || $fell(write_strobe_n_q) || $rose(addr_latch_strobe_q))
      |-> sys_clock_out_q)
    else $error("control asserted off a falling edge");

  AST_DEASSERT_FALL: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R21]
    ($rose(read_strobe_n_q) || $rose(write_strobe_n_q) || $fell(addr_latch_strobe_q) ||
     $fell(data_enable_n_q)) |-> !sys_clock_out_q)
    else $error("control deasserted or data enable asserted off a rising edge");

  AST_BURST_WORDS: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R22]
    ($rose(read_strobe_n_q) && cur_burst_q) |-> (words_q == BURST_WORDS))
    else $error("burst read ended without four words");

  AST_ACK_END: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R23]
    (state_q == ST_STROBE && cur_wr_q && !phase_q && ack_s) |-> ##2 write_strobe_n_q)
    else $error("write not ended on falling edge after acknowledge");

endmodule : wsb_bus_ctrl

// *** rtl/wsb_pkg.sv ***
// shared constants, types and state codes for the wait-state bus interface
package wsb_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int          AD_W        = 32;    // multiplexed address/data width
  localparam int          BE_W        = 4;     // byte enables on the low address bits
  localparam int          FIFO_DEPTH  = 8;     // queued processor requests
  localparam int          SYNC_IRQ_W  = 3;     // synchronous interrupt pins
  localparam int          FLOAT_BIT   = 1;     // irq pin that selects float-all at reset
  localparam logic [2:0]  BURST_WORDS = 3'h4;  // words returned by a burst read
  localparam logic [2:0]  WORDS_RST   = 3'h0;  // word counter reset value

  // ************************************************************
  // reset levels of the pins
  // ************************************************************
  localparam logic        STROBE_IDLE = 1'b1;  // active-low strobes rest high
  localparam logic        ALE_IDLE    = 1'b0;  // address latch strobe rests low
  localparam logic        OE_OFF      = 1'b0;  // output enable released
  localparam logic        PHASE_RST   = 1'b0;  // divided clock starts low

  // ************************************************************
  // types
  // ************************************************************
  // one processor bus request as queued in the fifo
  typedef struct packed {
    logic              wr;       // 1 = write cycle
    logic              burst;    // burst read or near write
    logic [BE_W-1:0]   byte_en;  // byte lanes taking part
    logic [AD_W-1:0]   addr;     // word address
    logic [AD_W-1:0]   wdata;    // write data
  } wsb_req_t;

  // bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,  // bus floated, controls negated
    ST_ADDR   = 3'b001,  // address phase, latch strobe high
    ST_STROBE = 3'b010,  // read or write strobe active
    ST_WHOLD  = 3'b011,  // write data held after strobe
    ST_GRANT  = 3'b100,  // bus handed to outside master
    ST_FLOAT  = 3'b101   // float-all test mode
  } wsb_state_t;

endpackage : wsb_pkg

// *** rtl/wsb_fifo.sv ***
// request fifo with parameterised width and depth, valid/ready on both sides
`timescale 1ns/1ns
module wsb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // ************************************************************
  // storage and pointers
  // ************************************************************
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;  // pointer width
  localparam int CW = $clog2(DEPTH + 1);                 // count width

  logic [W-1:0]  mem_q [DEPTH];  // word storage
  logic [PW-1:0] wr_ptr_q;       // next slot to fill
  logic [PW-1:0] rd_ptr_q;       // next slot to drain
  logic [CW-1:0] count_q;        // words held
  logic [CW-1:0] count_d;        // words held next cycle
  logic          push;           // word accepted
  logic          pop;            // word drained

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];

  // pointer step with wrap for any depth
  function automatic logic [PW-1:0] wsb_step(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction : wsb_step

  // next occupancy
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + CW'(1);
    end else if (pop && !push) begin
      count_d = count_q - CW'(1);
    end
  end

  // ************************************************************
  // state update
  // ************************************************************
  // pointers, count and registered ready
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      in_ready <= 1'b0;
    end else begin
      count_q  <= count_d;
      in_ready <= (count_d < CW'(DEPTH));  // full stalls the source
      if (push) begin
        wr_ptr_q <= wsb_step(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= wsb_step(rd_ptr_q);
      end
    end
  end

  // data array write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule : wsb_fifo

// *** verif/wsb_mem_model.sv ***
// memory-side partner: wait-state counter answering ready and ack
`timescale 1ns/1ns
module wsb_mem_model
  import wsb_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            clk_out,
  input  wire logic            ale,
  input  wire logic            rd_n,
  input  wire logic            wr_n,
  input  wire logic            burst_n,
  input  wire logic [AD_W-1:0] ad,
  input  wire logic [3:0]      waits,
  output logic                 ready_n  = 1'b1,
  output logic                 ack_n    = 1'b1,
  output logic                 mem_oe   = 1'b0,
  output logic [AD_W-1:0]      mem_data = '0,
  output logic                 wr_seen  = 1'b0,
  output logic [AD_W-1:0]      wr_addr  = '0,
  output logic [AD_W-1:0]      wr_data  = '0
);
  logic [3:0] cnt_q   = 4'h0;  // master cycle counter
  logic       brst_q  = 1'b0;  // burst flag of the address phase
  logic       wr_prev = 1'b1;  // write strobe one cycle ago
  // one step per system clock, taken after its rising edge
  always @(negedge sys_clk) begin
    wr_seen <= 1'b0;
    wr_prev <= wr_n;
    mem_oe  <= !rd_n;
    if (ale) begin
      wr_addr <= ad;
      brst_q  <= !burst_n;
    end
    // data must still stand in the cycle after the strobe ends
    if (wr_n && !wr_prev) begin
      wr_seen <= 1'b1;
      wr_data <= ad;
    end
    if (clk_out) begin
      ready_n <= 1'b1;
      ack_n   <= 1'b1;
      cnt_q   <= (rst_b && (!rd_n || !wr_n)) ? cnt_q + 4'h1 : 4'h0;
      if (!rd_n && cnt_q >= waits && cnt_q[0] == waits[0]
          && cnt_q < waits + (brst_q ? 4'h8 : 4'h2)) begin
        ready_n  <= 1'b0;
        mem_data <= (wr_addr ^ 32'h5A5A_0000) + AD_W'((cnt_q - waits) >> 1);
      end
      if (!wr_n && cnt_q == waits) ack_n <= 1'b0;
    end
  end
endmodule : wsb_mem_model

// *** verif/tb_wait_state_bus_control.sv ***
// bench: random traffic, handover with full fifo, float-all reset
`timescale 1ns/1ns
module tb_wait_state_bus_control
  import wsb_pkg::*;
;
  logic sys_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, bus_request_in = 1'b0;
  wsb_req_t req_data = '0;
  logic [SYNC_IRQ_W-1:0] sync_irq_in = '1;
  logic [3:0] waits = 4'h1;
  logic req_ready, rd_valid_q, wr_done_q, core_stall_q, sys_clock_out_q, ad_oe_q, ctl_oe_q;
  logic addr_latch_strobe_q, read_strobe_n_q, write_strobe_n_q, burst_or_near_write_n_q;
  logic data_enable_n_q, bus_grant_out_q, bus_grant_oe_q, read_word_ready_n, cycle_acknowledge_n;
  logic mem_oe, wr_seen, rd_p, wr_p, clk_p, rst_p;
  logic [AD_W-1:0] rd_data_q, ad_out_q, mem_data, wr_addr, wr_data, ad_w;
  logic [AD_W-1:0] exp_rd[$], exp_wa[$], exp_wd[$];
  int num_errors = 0, check_count = 0, cyc = 0, n_wr = 0, n_wexp = 0, n_acc;
  // released pins settle at their pull levels
  assign ad_w = ad_oe_q ? ad_out_q : (mem_oe ? mem_data : '1);
  wire logic ale_w = ctl_oe_q ? addr_latch_strobe_q : ALE_IDLE;
  wire logic rd_w  = ctl_oe_q ? read_strobe_n_q : STROBE_IDLE;
  wire logic wr_w  = ctl_oe_q ? write_strobe_n_q : STROBE_IDLE;
  wire logic bn_w  = ctl_oe_q ? burst_or_near_write_n_q : STROBE_IDLE;
  wsb_bus_ctrl dut (.sys_clk, .rst_b, .req_valid, .req_ready, .req_data, .rd_valid_q,
    .rd_data_q, .wr_done_q, .core_stall_q, .sys_clock_out_q, .ad_out_q, .ad_oe_q, .ad_in(ad_w),
    .addr_latch_strobe_q, .read_strobe_n_q, .write_strobe_n_q, .burst_or_near_write_n_q,
    .data_enable_n_q, .ctl_oe_q, .bus_grant_out_q, .bus_grant_oe_q, .bus_request_in,
    .read_word_ready_n, .cycle_acknowledge_n, .sync_irq_in);
  wsb_mem_model mem (.sys_clk, .rst_b, .clk_out(sys_clock_out_q), .ale(ale_w), .rd_n(rd_w),
    .wr_n(wr_w), .burst_n(bn_w), .ad(ad_w), .waits, .ready_n(read_word_ready_n),
    .ack_n(cycle_acknowledge_n), .mem_oe, .mem_data, .wr_seen, .wr_addr, .wr_data);
  initial forever #5 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk_word(input logic [AD_W-1:0] got, input logic [AD_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  function automatic wsb_req_t rnd_req();
    logic [95:0] x;
    x = {$urandom, $urandom, $urandom};
    return x[69:0];
  endfunction : rnd_req
  // expected words follow the partner's read data pattern
  task automatic expect_req(input wsb_req_t r);
    if (r.wr) begin
      exp_wa.push_back({r.addr[31:4], r.byte_en});
      exp_wd.push_back(r.wdata);
      n_wexp++;
    end else begin
      for (int k = 0; k < (r.burst ? int'(BURST_WORDS) : 1); k++)
        exp_rd.push_back(({r.addr[31:4], r.byte_en} ^ 32'h5A5A_0000) + AD_W'(k));
    end
  endtask : expect_req
  task automatic push(input wsb_req_t r);
    @(negedge sys_clk);
    while (req_ready !== 1'b1) begin
      req_valid <= 1'b0;
      @(negedge sys_clk);
    end
    req_valid <= 1'b1;
    req_data  <= r;
    expect_req(r);
  endtask : push
  task automatic do_reset(input logic [SYNC_IRQ_W-1:0] irq);
    @(negedge sys_clk);
    rst_b       <= 1'b0;
    req_valid   <= 1'b0;
    sync_irq_in <= irq;
    repeat (5) @(negedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : do_reset
  task automatic idle_chk();
    chk_bit(ad_oe_q, OE_OFF);
    chk_bit(ctl_oe_q, 1'b1);
    chk_bit(read_strobe_n_q & write_strobe_n_q & data_enable_n_q, STROBE_IDLE);
    chk_bit(burst_or_near_write_n_q | addr_latch_strobe_q, STROBE_IDLE);
  endtask : idle_chk
  task automatic drain();
    @(negedge sys_clk);
    req_valid <= 1'b0;
    for (int i = 0; i < 3000 && exp_rd.size() + exp_wd.size() > 0; i++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    idle_chk();
  endtask : drain
  // results and pin timing, looked at once the edge's updates have landed
  always @(negedge sys_clk) begin
    if (rd_valid_q === 1'b1) chk_word(rd_data_q, exp_rd.pop_front());
    if (wr_seen === 1'b1) chk_word(wr_addr, exp_wa.pop_front());
    if (wr_seen === 1'b1) chk_word(wr_data, exp_wd.pop_front());
    if (wr_done_q === 1'b1) n_wr++;
    if (rst_b && rst_p) chk_bit(sys_clock_out_q, !clk_p);
    if (rst_b && rst_p && read_strobe_n_q !== rd_p) chk_bit(sys_clock_out_q, rd_p);
    if (rst_b && rst_p && write_strobe_n_q !== wr_p) chk_bit(sys_clock_out_q, wr_p);
    rst_p = rst_b;
    clk_p = sys_clock_out_q;
    rd_p  = read_strobe_n_q;
    wr_p  = write_strobe_n_q;
  end
  initial begin
    wsb_req_t r;
    void'($urandom(61011));
    do_reset(3'h7);
    idle_chk();
    push({1'b0, 1'b1, 4'hF, 32'h0000_1230, 32'h0});  // burst read, then write turnaround
    push({1'b1, 1'b0, 4'h3, 32'h0000_1230, 32'hCAFE_0001});
    drain();
    for (int b = 0; b < 6; b++) begin
      waits <= 4'h1 + 4'($urandom_range(3));
      for (int i = 0; i < 6; i++) push(rnd_req());
      drain();
    end
    bus_request_in <= 1'b1;
    for (int i = 0; i < 20 && bus_grant_out_q !== 1'b1; i++) @(negedge sys_clk);
    chk_bit(bus_grant_out_q, 1'b1);
    chk_bit(bus_grant_oe_q & !ad_oe_q, 1'b1);
    chk_bit(ctl_oe_q, 1'b0);
    chk_bit(core_stall_q, 1'b0);
    n_acc = 0;
    for (int i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      r = rnd_req();
      req_data  <= r;
      req_valid <= req_ready;
      if (req_ready === 1'b1) expect_req(r);
      if (req_ready === 1'b1) n_acc++;
    end
    @(negedge sys_clk);
    req_valid <= 1'b0;
    chk_word(AD_W'(n_acc), AD_W'(FIFO_DEPTH));  // fifo refuses once full
    chk_bit(core_stall_q, 1'b1);
    chk_bit(ad_oe_q | ctl_oe_q, 1'b0);
    bus_request_in <= 1'b0;
    drain();
    chk_word(AD_W'(n_wr), AD_W'(n_wexp));
    do_reset(3'h5);
    push(rnd_req());
    @(negedge sys_clk);
    req_valid <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk_bit(core_stall_q, 1'b1);
    chk_bit(ad_oe_q | ctl_oe_q | bus_grant_oe_q, 1'b0);
    print_verdict();
  end
endmodule : tb_wait_state_bus_control
